/* lsc_host_model.sv */
// Behavioural host that shifts bytes into the serial command port
`timescale 1ns/1ns
module lsc_host_model
	import lsc_pkg::*;
(
	input wire logic clk,
	output logic cs_n,
	output logic sck,
	output logic si,
	output logic cmd_data
);
	int half = 6;

	// Idle: deselected, serial clock parked high
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b1;
		si = 1'b0;
		cmd_data = 1'b0;
	end

	// One byte per select window, each level held half clocks
	task automatic send(input lsc_byte_t byt);
		@(negedge clk);
		cs_n = 1'b0;
		cmd_data = byt.is_cmd;
		repeat (half) @(negedge clk);
		for (int i = 7; i >= 0; i--)
		begin
			sck = 1'b0;
			si = byt.value[i];
			repeat (half) @(negedge clk);
			sck = 1'b1;
			repeat (half) @(negedge clk);
		end
		cs_n = 1'b1;
		si = ~si; // Released line shows no stale level
		cmd_data = ~cmd_data;
		repeat (half) @(negedge clk);
	endtask
endmodule

/* lsc_pkg.sv */
// Shared constants and types of the serial LCD command controller
package lsc_pkg;

	// ****************************************************
	// Command codes
	// ****************************************************
	localparam logic [2:0] OP_MODE_SET = 3'h2;
	localparam logic [2:0] OP_POINTER = 3'h7;
	localparam logic [3:0] OP_WR_DISP = 4'hd;
	localparam logic [3:0] OP_WR_BLINK = 4'hc;
	localparam logic [7:0] CMD_XFER_CS = 8'h30;
	localparam logic [7:0] CMD_XFER_FRAME = 8'h31;
	localparam logic [7:0] CMD_XFER_HOLD = 8'h38;
	localparam logic [7:0] CMD_CLR_DISP = 8'h20;
	localparam logic [7:0] CMD_CLR_BLINK = 8'h00;

	// ****************************************************
	// Drive mode fields and reset values
	// ****************************************************
	localparam logic [1:0] BP_STATIC = 2'h1;
	localparam logic [1:0] BP_TWO = 2'h3;
	localparam logic [1:0] BP_THREE = 2'h2;
	localparam logic [1:0] BP_FOUR = 2'h0;
	localparam logic [1:0] PHASE_LAST_STATIC = 2'h0;
	localparam logic [1:0] PHASE_LAST_TWO = 2'h1;
	localparam logic [1:0] PHASE_LAST_THREE = 2'h2;
	localparam logic [1:0] PHASE_LAST_FOUR = 2'h3;
	localparam int DIV_WIDTH = 11;
	localparam logic [10:0] DIV_MASK_7 = 11'h07f;
	localparam logic [10:0] DIV_MASK_8 = 11'h0ff;
	localparam logic [10:0] DIV_MASK_9 = 11'h1ff;
	localparam logic [10:0] DIV_MASK_11 = 11'h7ff;
	localparam logic [4:0] POINTER_INIT = 5'h00;
	localparam logic [4:0] POINTER_LAST = 5'h1f;

	// ****************************************************
	// Pin synchroniser layout
	// ****************************************************
	localparam int PIN_COUNT = 5;
	localparam int PIN_CS = 0;
	localparam int PIN_SCK = 1;
	localparam int PIN_SI = 2;
	localparam int PIN_CD = 3;
	localparam int PIN_SYNC = 4;
	localparam logic [4:0] PIN_IDLE = 5'h13;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// ****************************************************
	// Types
	// ****************************************************
	typedef struct packed {
		logic bias_half;
		logic [1:0] backplanes;
		logic [1:0] freq;
	} lsc_mode_t;

	localparam lsc_mode_t MODE_RESET = '{1'b0, BP_FOUR, 2'h0};

	typedef struct packed {
		logic is_cmd;
		logic [7:0] value;
	} lsc_byte_t;

	typedef enum logic [1:0] {
		XFER_CS = 2'b00,
		XFER_FRAME = 2'b01,
		XFER_HOLD = 2'b10
	} lsc_xfer_t;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_CLEAR = 2'b01,
		ENG_COPY = 2'b10,
		ENG_DIGIT = 2'b11
	} lsc_eng_t;

endpackage

/* lsc_ram.sv */
// Single port 32 x 4 memory with registered read data
`timescale 1ns/1ns
module lsc_ram
	import lsc_pkg::*;
#(
	parameter int WIDTH = 4,
	parameter int DEPTH = 32,
	parameter int ADDR_W = 5
)
(
	input wire logic clk,
	input wire logic we,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	// ****************************************************
	// Write and registered read
	// ****************************************************
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr]; // Old data on a write
	end

endmodule

/* lsc_top.sv */
// Serial command interpreter and drive sequencer of the LCD controller
// Function
// - Top bits 010 decode as mode set
// - Bits 3:2 choose one to four backplanes
// - Bit 4 picks one-third or one-half bias, ignored in static drive
// - Bits 1:0 divide clock by 2^7, 2^8, 2^9 or 2^11
// - Frame rate is A/C rate over backplanes
// - 0x30 copies RAM on chip select rise
// - 0x31 copies RAM on frame clock rise
// - 0x38 suspends transfer, protocol state kept
// - 0x20 zeroes display RAM, resets pointer
// - 0x00 zeroes blink RAM, resets pointer
// - Top bits 111 load five-bit pointer
// - 1101 writes display nibble, pointer increments
// - Eight-bit words over clock and data lines
// - Four backplanes, thirty-two segments, kept synchronised
// - Separate display and blink RAMs, 32x4
// - Numeric decoder fits sixteen characters
// - Open-drain sync pin aligns cascaded devices
`timescale 1ns/1ns
module lsc_top
	import lsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic cmd_data,
	input wire logic sync_in,
	output logic sync_out,
	output logic sync_oe_n,
	output logic [31:0] segment_outputs,
	output logic [3:0] backplane_outputs,
	output logic drive_polarity,
	output logic bias_half,
	output logic frame_clock,
	output logic [4:0] data_pointer,
	output logic busy
);

	// ****************************************************
	// Declarations
	// ****************************************************
	logic [PIN_COUNT-1:0] pins;
	logic [PIN_COUNT-1:0] sync_a;
	logic [PIN_COUNT-1:0] sync_b;
	logic [PIN_COUNT-1:0] sync_c;
	logic [PIN_COUNT-1:0] pin_f;
	logic [PIN_COUNT-1:0] pin_d;
	logic cs_rise;
	logic sck_rise;
	logic sync_fall;
	logic [2:0] bit_cnt;
	logic [6:0] shift;
	logic rx_valid;
	lsc_byte_t rx_byte;
	lsc_byte_t pend;
	logic pend_valid;
	logic take_cmd;
	lsc_mode_t mode;
	lsc_xfer_t xfer;
	lsc_eng_t eng;
	logic [4:0] scan;
	logic clear_blink;
	logic [3:0] digit_lo;
	logic copy_req;
	logic start_copy;
	logic copy_valid;
	logic [4:0] copy_addr;
	logic [DIV_WIDTH-1:0] div;
	logic [DIV_WIDTH-1:0] div_mask;
	logic ac_tick;
	logic [1:0] phase;
	logic [1:0] phase_last;
	logic frame_tick;
	logic is_mode;
	logic is_pointer;
	logic is_wr_disp;
	logic is_wr_blink;
	logic is_data;
	logic [7:0] digit_seg;
	logic disp_we;
	logic [4:0] disp_addr;
	logic [3:0] disp_wdata;
	logic [3:0] disp_rdata;
	logic blink_we;
	logic [4:0] blink_addr;
	logic [3:0] blink_wdata;
	logic [3:0] seg_latch [32];

	// ****************************************************
	// Pin synchronisers
	// ****************************************************
	assign pins = {sync_in, cmd_data, si, sck, cs_n};

	// Three stages; a level counts once the last two agree
	genvar gp;
	generate
		for (gp = 0; gp < PIN_COUNT; gp++)
		begin : g_pin
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					sync_a[gp] <= PIN_IDLE[gp];
					sync_b[gp] <= PIN_IDLE[gp];
					sync_c[gp] <= PIN_IDLE[gp];
					pin_f[gp] <= PIN_IDLE[gp];
					pin_d[gp] <= PIN_IDLE[gp];
				end
				else
				begin
					sync_a[gp] <= pins[gp];
					sync_b[gp] <= sync_a[gp];
					sync_c[gp] <= sync_b[gp];
					if (sync_b[gp] == sync_c[gp])
					begin
						pin_f[gp] <= sync_c[gp];
					end
					pin_d[gp] <= pin_f[gp];
				end
			end
		end
	endgenerate

	// Edges of the filtered levels
	assign cs_rise = pin_f[PIN_CS] && !pin_d[PIN_CS];
	assign sck_rise = pin_f[PIN_SCK] && !pin_d[PIN_SCK];
	assign sync_fall = !pin_f[PIN_SYNC] && pin_d[PIN_SYNC];

	// ****************************************************
	// Serial receiver
	// ****************************************************
	// Bits enter MSB first while chip select is low
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			bit_cnt <= 3'h0;
			shift <= 7'h00;
		end
		else if (pin_f[PIN_CS])
		begin
			bit_cnt <= 3'h0;
		end
		else if (sck_rise)
		begin
			shift <= {shift[5:0], pin_f[PIN_SI]};
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// A byte completes on the eighth clock edge
	assign rx_valid = !pin_f[PIN_CS] && sck_rise && (bit_cnt == BIT_LAST);
	assign rx_byte = '{pin_f[PIN_CD], {shift, pin_f[PIN_SI]}};

	// One pending byte; a new byte beats its own consumption
	assign take_cmd = pend_valid && (eng == ENG_IDLE);
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pend_valid <= 1'b0;
			pend <= '0;
		end
		else if (rx_valid && (!pend_valid || take_cmd))
		begin
			pend <= rx_byte;
			pend_valid <= 1'b1;
		end
		else if (take_cmd)
		begin
			pend_valid <= 1'b0;
		end
	end

	// ****************************************************
	// Command decode
	// ****************************************************
	assign is_mode = pend.is_cmd && (pend.value[7:5] == OP_MODE_SET);
	assign is_pointer = pend.is_cmd && (pend.value[7:5] == OP_POINTER);
	assign is_wr_disp = pend.is_cmd && (pend.value[7:4] == OP_WR_DISP);
	assign is_wr_blink = pend.is_cmd && (pend.value[7:4] == OP_WR_BLINK);
	assign is_data = !pend.is_cmd;

	// Numeric decoder, data bit 4 is the decimal point
	always_comb
	begin
		unique case (pend.value[3:0])
			4'h0: digit_seg = 8'h3f;
			4'h1: digit_seg = 8'h06;
			4'h2: digit_seg = 8'h5b;
			4'h3: digit_seg = 8'h4f;
			4'h4: digit_seg = 8'h66;
			4'h5: digit_seg = 8'h6d;
			4'h6: digit_seg = 8'h7d;
			4'h7: digit_seg = 8'h07;
			4'h8: digit_seg = 8'h7f;
			4'h9: digit_seg = 8'h6f;
			4'ha: digit_seg = 8'h77;
			4'hb: digit_seg = 8'h7c;
			4'hc: digit_seg = 8'h39;
			4'hd: digit_seg = 8'h5e;
			4'he: digit_seg = 8'h79;
			4'hf: digit_seg = 8'h71;
		endcase
		digit_seg[7] = pend.value[4];
	end

	// Drive mode register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mode <= MODE_RESET;
		end
		else if (take_cmd && is_mode)
		begin
			mode <= lsc_mode_t'(pend.value[4:0]);
		end
	end

	// Transfer mode: chip select, frame clock or suspended
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			xfer <= XFER_CS;
		end
		else if (take_cmd && pend.is_cmd)
		begin
			if (pend.value == CMD_XFER_CS)
			begin
				xfer <= XFER_CS;
			end
			else if (pend.value == CMD_XFER_FRAME)
			begin
				xfer <= XFER_FRAME;
			end
			else if (pend.value == CMD_XFER_HOLD)
			begin
				xfer <= XFER_HOLD;
			end
		end
	end

	// ****************************************************
	// Data pointer
	// ****************************************************
	// Natural 5-bit wrap takes 31 back to 0
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			data_pointer <= POINTER_INIT;
		end
		else if (eng == ENG_DIGIT)
		begin
			data_pointer <= data_pointer + 5'h01;
		end
		else if (take_cmd)
		begin
			if (is_pointer)
			begin
				data_pointer <= pend.value[4:0];
			end
			else if (is_wr_disp || is_wr_blink || is_data)
			begin
				data_pointer <= data_pointer + 5'h01;
			end
			else if (pend.is_cmd && (pend.value == CMD_CLR_DISP ||
				pend.value == CMD_CLR_BLINK))
			begin
				data_pointer <= POINTER_INIT;
			end
		end
	end

	// ****************************************************
	// Memory engine
	// ****************************************************
	// Transfer requests wait until the engine is free
	assign start_copy = (eng == ENG_IDLE) && !take_cmd && copy_req;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			copy_req <= 1'b0;
		end
		else if ((xfer == XFER_CS && cs_rise) ||
			(xfer == XFER_FRAME && frame_tick))
		begin
			copy_req <= 1'b1;
		end
		else if (start_copy || xfer == XFER_HOLD)
		begin
			copy_req <= 1'b0;
		end
	end

	// Clear, copy and second digit write sequencing
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			eng <= ENG_IDLE;
			scan <= POINTER_INIT;
			clear_blink <= 1'b0;
			digit_lo <= 4'h0;
		end
		else
		begin
			unique case (eng)
				ENG_IDLE:
				begin
					scan <= POINTER_INIT;
					if (take_cmd && pend.is_cmd &&
						pend.value == CMD_CLR_DISP)
					begin
						eng <= ENG_CLEAR;
						clear_blink <= 1'b0;
					end
					else if (take_cmd && pend.is_cmd &&
						pend.value == CMD_CLR_BLINK)
					begin
						eng <= ENG_CLEAR;
						clear_blink <= 1'b1;
					end
					else if (take_cmd && is_data)
					begin
						eng <= ENG_DIGIT;
						digit_lo <= digit_seg[3:0];
					end
					else if (start_copy)
					begin
						eng <= ENG_COPY;
					end
				end
				ENG_CLEAR, ENG_COPY:
				begin
					scan <= scan + 5'h01;
					if (scan == POINTER_LAST)
					begin
						eng <= ENG_IDLE;
					end
				end
				ENG_DIGIT:
				begin
					eng <= ENG_IDLE;
				end
			endcase
		end
	end

	assign busy = pend_valid || (eng != ENG_IDLE) || copy_req;

	// Display RAM port steering
	always_comb
	begin
		disp_addr = data_pointer;
		disp_we = 1'b0;
		disp_wdata = pend.value[3:0];
		if (eng == ENG_CLEAR || eng == ENG_COPY)
		begin
			disp_addr = scan;
			disp_we = (eng == ENG_CLEAR) && !clear_blink;
			disp_wdata = 4'h0;
		end
		else if (eng == ENG_DIGIT)
		begin
			disp_we = 1'b1;
			disp_wdata = digit_lo;
		end
		else if (take_cmd && is_data)
		begin
			disp_we = 1'b1;
			disp_wdata = digit_seg[7:4];
		end
		else if (take_cmd && is_wr_disp)
		begin
			disp_we = 1'b1;
		end
	end

	// Blink RAM port steering, shares the pointer
	always_comb
	begin
		blink_addr = data_pointer;
		blink_we = take_cmd && is_wr_blink && (eng == ENG_IDLE);
		blink_wdata = pend.value[3:0];
		if (eng == ENG_CLEAR)
		begin
			blink_addr = scan;
			blink_we = clear_blink;
			blink_wdata = 4'h0;
		end
	end

	// Two separate 32 x 4 arrays
	lsc_ram #(.WIDTH(4), .DEPTH(32), .ADDR_W(5)) u_disp_ram
	(
		.clk(clk),
		.we(disp_we),
		.addr(disp_addr),
		.wdata(disp_wdata),
		.rdata(disp_rdata)
	);

	lsc_ram #(.WIDTH(4), .DEPTH(32), .ADDR_W(5)) u_blink_ram
	(
		.clk(clk),
		.we(blink_we),
		.addr(blink_addr),
		.wdata(blink_wdata),
		.rdata()
	);

	// Read data lands one cycle after its address
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			copy_valid <= 1'b0;
			copy_addr <= POINTER_INIT;
		end
		else
		begin
			copy_valid <= (eng == ENG_COPY);
			copy_addr <= scan;
		end
	end

	// ****************************************************
	// A/C divider, backplane phase and sync pin
	// ****************************************************
	always_comb
	begin
		unique case (mode.freq)
			2'h0: div_mask = DIV_MASK_7;
			2'h1: div_mask = DIV_MASK_8;
			2'h2: div_mask = DIV_MASK_9;
			2'h3: div_mask = DIV_MASK_11;
		endcase
		unique case (mode.backplanes)
			BP_STATIC: phase_last = PHASE_LAST_STATIC;
			BP_TWO: phase_last = PHASE_LAST_TWO;
			BP_THREE: phase_last = PHASE_LAST_THREE;
			BP_FOUR: phase_last = PHASE_LAST_FOUR;
		endcase
	end

	assign ac_tick = ((div & div_mask) == div_mask);
	assign frame_tick = ac_tick && (phase == phase_last);

	// Another device pulling sync low realigns this one
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			div <= '0;
			phase <= 2'h0;
			drive_polarity <= 1'b0;
		end
		else if (sync_fall && sync_oe_n)
		begin
			div <= '0;
			phase <= 2'h0;
			drive_polarity <= 1'b0;
		end
		else
		begin
			div <= div + 11'h001;
			if (frame_tick)
			begin
				phase <= 2'h0;
				drive_polarity <= !drive_polarity;
			end
			else if (ac_tick)
			begin
				phase <= phase + 2'h1;
			end
		end
	end

	// Open drain: pull low during the first backplane slot
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync_oe_n <= 1'b1;
			frame_clock <= 1'b0;
		end
		else
		begin
			sync_oe_n <= (phase != 2'h0);
			frame_clock <= frame_tick;
		end
	end
	assign sync_out = 1'b0;

	// ****************************************************
	// Segment latches and drive outputs
	// ****************************************************
	genvar gs;
	generate
		for (gs = 0; gs < 32; gs++)
		begin : g_seg
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					seg_latch[gs] <= 4'h0;
					segment_outputs[gs] <= 1'b0;
				end
				else
				begin
					if (copy_valid && copy_addr == 5'(gs))
					begin
						seg_latch[gs] <= disp_rdata;
					end
					segment_outputs[gs] <= seg_latch[gs][phase];
				end
			end
		end
	endgenerate

	// Backplane select follows the same phase as the segments
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			backplane_outputs <= 4'h0;
			bias_half <= 1'b0;
		end
		else
		begin
			backplane_outputs <= 4'h1 << phase;
			bias_half <= mode.bias_half &&
				(mode.backplanes != BP_STATIC);
		end
	end

endmodule

/* lsc_top_assertions.sv */
// Concurrent checks on the ports of the LCD command controller
`timescale 1ns/1ns
module lsc_top_checker
	import lsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic cmd_data,
	input wire logic sync_in,
	input wire logic sync_out,
	input wire logic sync_oe_n,
	input wire logic [31:0] segment_outputs,
	input wire logic [3:0] backplane_outputs,
	input wire logic drive_polarity,
	input wire logic bias_half,
	input wire logic frame_clock,
	input wire logic [4:0] data_pointer,
	input wire logic busy
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ****************************************************
	// Drive timing
	// ****************************************************
	a_sync_out_low: assert property (sync_out == 1'b0)
		else $error("sync value not low");
	a_sync_phase_zero: assert property (
		!sync_oe_n |-> backplane_outputs == 4'h1)
		else $error("sync pulled outside phase zero");
	a_bp_one_hot: assert property (
		$past(rst_n) |-> $onehot(backplane_outputs))
		else $error("backplanes not one-hot");
	a_frame_single: assert property (
		frame_clock |=> (!frame_clock) [*8])
		else $error("frame pulse too long");
	a_frame_phase: assert property (
		frame_clock |-> ##[0:1] backplane_outputs == 4'h1)
		else $error("frame pulse off phase zero");
	a_polarity_frame: assert property (
		$changed(drive_polarity) |-> ##[0:2] frame_clock)
		else $error("polarity moved without frame");

	// ****************************************************
	// Command side
	// ****************************************************
	a_pointer_held: assert property (
		$past(!busy) && $past(rst_n) |-> $stable(data_pointer))
		else $error("pointer moved while idle");
	a_segment_copy: assert property (
		$changed(segment_outputs) && $stable(backplane_outputs)
		&& $past(backplane_outputs) == $past(backplane_outputs, 2)
		|-> busy || $past(busy) || $past(busy, 2) || $past(busy, 3))
		else $error("segments changed without copy");

	// Main scenarios reached
	c_frame: cover property (frame_clock);
	c_sync: cover property (!sync_oe_n);
	c_copy: cover property ($changed(segment_outputs));
endmodule

bind lsc_top lsc_top_checker u_chk (
	.clk(clk),
	.rst_n(rst_n),
	.cs_n(cs_n),
	.sck(sck),
	.si(si),
	.cmd_data(cmd_data),
	.sync_in(sync_in),
	.sync_out(sync_out),
	.sync_oe_n(sync_oe_n),
	.segment_outputs(segment_outputs),
	.backplane_outputs(backplane_outputs),
	.drive_polarity(drive_polarity),
	.bias_half(bias_half),
	.frame_clock(frame_clock),
	.data_pointer(data_pointer),
	.busy(busy)
);

/* lsc_top_tb.sv */
// Self-checking bench of the LCD command controller
`timescale 1ns/1ns
module lsc_top_tb
	import lsc_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n, sck, si, cmd_data, sync_in, sync_out, sync_oe_n;
	logic [31:0] segment_outputs, exp_bits;
	logic [3:0] backplane_outputs;
	logic drive_polarity, bias_half, frame_clock, busy;
	logic [4:0] data_pointer, ptr;
	logic [7:0] v, bt, code;
	logic [7:0] seg_code [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66,
		8'h6d, 8'h7d, 8'h07, 8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e,
		8'h79, 8'h71};
	int fails = 0;
	int samples_checked = 0;
	int n, op, seed;

	// Clock and open-drain sync wire with pull-up
	always #25 clk = ~clk;
	assign sync_in = sync_oe_n;

	lsc_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
		.cmd_data(cmd_data));
	lsc_top uut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
		.si(si), .cmd_data(cmd_data), .sync_in(sync_in),
		.sync_out(sync_out), .sync_oe_n(sync_oe_n),
		.segment_outputs(segment_outputs),
		.backplane_outputs(backplane_outputs),
		.drive_polarity(drive_polarity), .bias_half(bias_half),
		.frame_clock(frame_clock), .data_pointer(data_pointer),
		.busy(busy));

	// ****************************************************
	// Helpers
	// ****************************************************
	task automatic finish_test;
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check_vec(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t %s: %h not %h", $time, what, got, exp);
		end
	endtask

	task automatic check_cnt(input int got, input int exp, input string what);
		samples_checked++;
		if (got != exp)
		begin
			fails++;
			$display("CHECK FAILED %0t %s: %0d not %0d", $time, what, got, exp);
		end
	endtask

	task automatic check_ptr(input logic [4:0] exp);
		check_vec({27'h0, data_pointer}, {27'h0, exp}, "pointer");
	endtask

	// Send one byte, let the filtered select rise, then wait for the engine
	task automatic send(input logic c, input logic [7:0] b);
		host.send(lsc_byte_t'{c, b});
		repeat (2) @(negedge clk); // Copy request lags the select pin
		for (int i = 0; i < 300 && busy !== 1'b0; i++)
			@(negedge clk);
		repeat (3) @(negedge clk);
	endtask

	// Cycles between two frame pulses
	task automatic frame_len(output int len);
		for (int i = 0; i < 20000 && frame_clock !== 1'b1; i++)
			@(negedge clk);
		@(negedge clk);
		for (len = 1; len < 20000 && frame_clock !== 1'b1; len++)
			@(negedge clk);
	endtask

	function automatic int frame_exp(input logic [1:0] bp, input logic [1:0] f);
		int div;
		div = (f == 2'h3) ? 2048 : (128 << f);
		case (bp)
			BP_STATIC: return div;
			BP_TWO: return div * 2;
			BP_THREE: return div * 3;
			default: return div * 4;
		endcase
	endfunction

	// ****************************************************
	// Test sequence
	// ****************************************************
	initial
	begin
		seed = $urandom(32'h9866);
		repeat (5) @(negedge clk);
		check_ptr(5'h00);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		send(1'b1, 8'hff);
		check_ptr(5'h1f);
		send(1'b1, 8'hd5);
		check_ptr(5'h00);
		send(1'b1, 8'he7);
		send(1'b1, 8'h20);
		check_ptr(5'h00);
		send(1'b1, 8'he9);
		send(1'b1, 8'h00);
		check_ptr(5'h00);
		for (int b = 0; b < 4; b++)
		begin
			send(1'b1, {3'h2, b[0], b[1:0], 2'h0});
			frame_len(n);
			check_cnt(n, frame_exp(b[1:0], 2'h0), "frame bp");
			check_vec({31'h0, bias_half},
				{31'h0, b[0] && b[1:0] != BP_STATIC}, "bias");
			check_vec({28'h0, backplane_outputs},
				32'(4'h1 << (frame_exp(b[1:0], 2'h0) / 128 - 1)), "last bp");
		end
		for (int f = 0; f < 4; f++)
		begin
			send(1'b1, {6'h11, f[1:0]});
			frame_len(n);
			check_cnt(n, frame_exp(BP_STATIC, f[1:0]), "frame div");
		end
		send(1'b1, 8'h44);
		send(1'b1, 8'h30);
		send(1'b1, 8'h20);
		send(1'b1, 8'hd1);
		check_vec(segment_outputs, 32'h0000_0001, "cs copy");
		send(1'b1, 8'h38);
		send(1'b1, 8'hd1);
		repeat (300) @(negedge clk);
		check_vec(segment_outputs, 32'h0000_0001, "held");
		send(1'b1, 8'h31);
		repeat (300) @(negedge clk);
		check_vec(segment_outputs, 32'h0000_0003, "frame copy");
		send(1'b1, 8'h30);
		send(1'b1, 8'h20);
		exp_bits = 32'h0000_0000;
		ptr = 5'h00;
		repeat (30)
		begin
			op = $urandom_range(3, 0);
			v = 8'($urandom);
			host.half = $urandom_range(8, 4);
			bt = (op == 0) ? {3'h7, v[4:0]} : (op == 1) ? {4'hd, v[3:0]} :
				(op == 2) ? {4'hc, v[3:0]} : {3'h0, v[4:0]};
			send(op != 3, bt);
			if (op == 0)
				ptr = v[4:0];
			else if (op == 3)
			begin
				code = seg_code[v[3:0]] | {v[4], 7'h00};
				exp_bits[ptr] = code[4];
				exp_bits[ptr + 5'h01] = code[0];
				ptr = ptr + 5'h02;
			end
			else
			begin
				if (op == 1)
					exp_bits[ptr] = v[0];
				ptr = ptr + 5'h01;
			end
			check_ptr(ptr);
		end
		check_vec(segment_outputs, exp_bits, "ram image");
		finish_test;
	end

	// Watchdog against a hung handshake
	initial
	begin
		repeat (60000) @(posedge clk);
		fails++;
		finish_test;
	end
endmodule
